//--- hdl/psl_pkg.sv
`default_nettype none
package psl_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_UPPER  = 8'h04;
	localparam logic [7:0] ADDR_LOWER  = 8'h08;
	localparam logic [7:0] ADDR_DEVLIM = 8'h0C;
	localparam logic [7:0] ADDR_SWITCH = 8'h10;
	localparam logic [7:0] ADDR_INTTM  = 8'h14;
	localparam logic [7:0] ADDR_TERM_A = 8'h18;
	localparam logic [7:0] ADDR_TERM_B = 8'h1C;
	localparam logic [7:0] ADDR_FLAGS  = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h24;
	localparam logic [7:0] ADDR_MASK   = 8'h28;
	// control register fields
	localparam int CTRL_LAS_LSB = 0;
	localparam int CTRL_CAS_LSB = 8;
	// setting that switches a limit, a detect time or the switchover off
	localparam logic [15:0] DISABLE_VAL = 16'h270F;
	// switchover ceiling, 400.00 Hz in 0.01 Hz steps
	localparam logic [15:0] SWITCH_MAX  = 16'h9C40;
	// values after reset
	localparam logic [7:0]  RST_LAS    = 8'h00;
	localparam logic [7:0]  RST_CAS    = 8'h14;
	localparam logic [15:0] RST_LIMIT  = DISABLE_VAL;
	localparam logic [15:0] RST_SWITCH = DISABLE_VAL;
	localparam logic [15:0] RST_INTTM  = DISABLE_VAL;
	localparam logic [7:0]  RST_CODE   = 8'h00;
	localparam logic [5:0]  RST_MASK   = 6'h00;
	// output terminal assignment codes
	localparam logic [7:0] CODE_LOWER = 8'h0E;
	localparam logic [7:0] CODE_UPPER = 8'h0F;
	localparam logic [7:0] CODE_DIR   = 8'h10;
	localparam logic [7:0] CODE_LOOP  = 8'h2F;
	localparam logic [7:0] CODE_DEV   = 8'h30;
	localparam logic [7:0] CODE_SLEEP = 8'h46;
	localparam logic [7:0] CODE_NEG   = 8'h64;
	// control action selections
	localparam logic [7:0] CAS_DEV_A0 = 8'h0A;
	localparam logic [7:0] CAS_DEV_A1 = 8'h0B;
	localparam logic [7:0] CAS_DEV_B0 = 8'h6E;
	localparam logic [7:0] CAS_DEV_B1 = 8'h6F;
	localparam logic [7:0] CAS_BUSDEV0 = 8'h32;
	localparam logic [7:0] CAS_BUSDEV1 = 8'h33;
	localparam logic [7:0] CAS_BUSSM0  = 8'h3C;
	localparam logic [7:0] CAS_BUSSM1  = 8'h3D;
	// limit action selections
	localparam logic [7:0] LAS_1  = 8'h01;
	localparam logic [7:0] LAS_2  = 8'h02;
	localparam logic [7:0] LAS_3  = 8'h03;
	localparam logic [7:0] LAS_10 = 8'h0A;
	localparam logic [7:0] LAS_11 = 8'h0B;
	localparam logic [7:0] LAS_12 = 8'h0C;
	localparam logic [7:0] LAS_13 = 8'h0D;
	// event bits of status and mask
	localparam int EV_UPPER = 0;
	localparam int EV_LOWER = 1;
	localparam int EV_DEV   = 2;
	localparam int EV_FAULT = 3;
	localparam int EV_SLEEP = 4;
	localparam int EV_LOOP  = 5;
	localparam int EV_W     = 6;
	// loop supervision states
	typedef enum logic [1:0] {LOOP_OPEN, LOOP_RUN, LOOP_FAULT} psl_loop_t;
endpackage : psl_pkg
`default_nettype wire

//--- hdl/psl_limit_check.sv
`default_nettype none
module psl_limit_check #(
	parameter int  VW    = 17,
	parameter bit  ABOVE = 1'b1,
	parameter bit  MAG   = 1'b0
) (
	input  wire logic                 mclk,
	input  wire logic                 reset,
	input  wire logic                 enable,
	input  wire logic signed [VW-1:0] value,
	input  wire logic        [15:0]   limit,
	output logic                      flag
);
	typedef struct packed {
		logic flag;
	} psl_chk_t;

	psl_chk_t q;
	psl_chk_t next_q;
	logic signed [VW-1:0] mag;
	logic signed [VW-1:0] lim;

	generate
		if (VW < 17)
			$error("value width too small for limit compare");
	endgenerate

	// magnitude and compare; a disabled limit never flags
	always_comb
	begin
		next_q = q;
		mag = (MAG && value < 0) ? -value : value;
		lim = $signed({{(VW-16){1'b0}}, limit});
		if (!enable || limit == psl_pkg::DISABLE_VAL)
			next_q.flag = 1'b0;
		else if (ABOVE)
			next_q.flag = mag > lim;
		else
			next_q.flag = mag < lim;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			q <= '0;
		else
			q <= next_q;
	end

	assign flag = q.flag;
endmodule : psl_limit_check
`default_nettype wire

//--- hdl/psl_term_map.sv
`default_nettype none
module psl_term_map #(
	parameter int NUM_TERM = 7
) (
	input  wire logic                     mclk,
	input  wire logic                     reset,
	input  wire logic [NUM_TERM-1:0][7:0] code,
	input  wire logic                     upperFlag,
	input  wire logic                     lowerFlag,
	input  wire logic                     dirFlag,
	input  wire logic                     loopFlag,
	input  wire logic                     devFlag,
	input  wire logic                     sleepFlag,
	output logic      [NUM_TERM-1:0]      term
);
	typedef struct packed {
		logic [NUM_TERM-1:0] term;
	} psl_map_t;

	psl_map_t q;
	psl_map_t next_q;
	logic [NUM_TERM-1:0] level;

	// per terminal: strip the negative offset, pick the function, invert
	for (genvar i = 0; i < NUM_TERM; i++)
	begin : g_term
		logic       neg;
		logic [7:0] fn;
		logic       hit;
		assign neg = code[i] >= psl_pkg::CODE_NEG;
		assign fn  = neg ? code[i] - psl_pkg::CODE_NEG : code[i];
		always_comb
		begin
			hit = 1'b0;
			unique case (fn)
				psl_pkg::CODE_UPPER: hit = upperFlag;
				psl_pkg::CODE_LOWER: hit = lowerFlag;
				psl_pkg::CODE_DIR:   hit = dirFlag;
				psl_pkg::CODE_LOOP:  hit = loopFlag;
				psl_pkg::CODE_SLEEP: hit = sleepFlag;
				psl_pkg::CODE_DEV:   hit = devFlag;
				default:             hit = 1'b0;
			endcase
		end
		// unknown codes sit at the inactive level of their polarity
		assign level[i] = neg ? ~hit : hit;
	end

	always_comb
	begin
		next_q = q;
		next_q.term = level;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			q <= '0;
		else
			q <= next_q;
	end

	assign term = q.term;
endmodule : psl_term_map
`default_nettype wire

//--- hdl/psl_supervisor.sv
`default_nettype none
module psl_supervisor #(
	parameter int VALUE_W  = 16,
	parameter int NUM_TERM = 7
) (
	input  wire logic                      mclk,
	input  wire logic                      reset,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic        [7:0]         paddr,
	input  wire logic        [31:0]        pwdata,
	output logic             [31:0]        prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic signed [VALUE_W-1:0] analogSetValue,
	input  wire logic signed [VALUE_W-1:0] analogMeasured,
	input  wire logic signed [VALUE_W-1:0] analogDeviation,
	input  wire logic signed [VALUE_W-1:0] busSetValue,
	input  wire logic signed [VALUE_W-1:0] busMeasured,
	input  wire logic signed [VALUE_W-1:0] busDeviation,
	input  wire logic        [15:0]        outputFreq,
	input  wire logic                      runActive,
	input  wire logic                      dirForward,
	input  wire logic                      loopEnableInput,
	input  wire logic                      integralResetInput,
	input  wire logic                      sleepRequest,
	output logic             [NUM_TERM-1:0] terminalOut,
	output logic signed      [VALUE_W:0]   deviationOut,
	output logic                           loopActive,
	output logic                           outputShutoff,
	output logic                           decelStop,
	output logic                           integralClear,
	output logic                           irq
);
	localparam int DW = VALUE_W + 1;

	typedef struct packed {
		logic [31:0]               prdata;
		logic                      pready;
		logic                      pslverr;
		logic [psl_pkg::EV_W-1:0]  rdSnap;
		logic [7:0]                las;
		logic [7:0]                cas;
		logic [15:0]               upperLim;
		logic [15:0]               lowerLim;
		logic [15:0]               devLim;
		logic [15:0]               switchFreq;
		logic [15:0]               detectTime;
		logic [7:0][7:0]           code;
		logic signed [DW-1:0]      measured;
		logic signed [DW-1:0]      deviation;
		logic                      gateLimits;
		psl_pkg::psl_loop_t        state;
		logic                      loopOn;
		logic                      sleepOn;
		logic                      dirFlag;
		logic                      shutoff;
		logic                      decel;
		logic                      intClear;
		logic [psl_pkg::EV_W-1:0]  prevEv;
		logic [psl_pkg::EV_W-1:0]  status;
		logic [psl_pkg::EV_W-1:0]  mask;
		logic                      irq;
	} psl_sup_t;

	psl_sup_t q;
	psl_sup_t next_q;

	logic upperFlag;
	logic lowerFlag;
	logic devFlag;
	logic [NUM_TERM-1:0][7:0] termCode;

	generate
		if (VALUE_W < 16 || VALUE_W > 30)
			$error("VALUE_W must lie between 16 and 30");
		if (NUM_TERM < 1 || NUM_TERM > 8)
			$error("NUM_TERM must lie between 1 and 8");
	endgenerate

	// measured value signed limit checks; deviation-input modes have none
	psl_limit_check #(.VW(DW), .ABOVE(1'b1), .MAG(1'b0)) u_upper (
		.mclk   (mclk),
		.reset  (reset),
		.enable (q.gateLimits),
		.value  (q.measured),
		.limit  (q.upperLim),
		.flag   (upperFlag)
	);

	psl_limit_check #(.VW(DW), .ABOVE(1'b0), .MAG(1'b0)) u_lower (
		.mclk   (mclk),
		.reset  (reset),
		.enable (q.gateLimits),
		.value  (q.measured),
		.limit  (q.lowerLim),
		.flag   (lowerFlag)
	);

	psl_limit_check #(.VW(DW), .ABOVE(1'b1), .MAG(1'b1)) u_dev (
		.mclk   (mclk),
		.reset  (reset),
		.enable (1'b1),
		.value  (q.deviation),
		.limit  (q.devLim),
		.flag   (devFlag)
	);

	assign termCode = q.code[NUM_TERM-1:0];

	psl_term_map #(.NUM_TERM(NUM_TERM)) u_map (
		.mclk      (mclk),
		.reset     (reset),
		.code      (termCode),
		.upperFlag (upperFlag),
		.lowerFlag (lowerFlag),
		.dirFlag   (q.dirFlag),
		.loopFlag  (q.state == psl_pkg::LOOP_RUN),
		.devFlag   (devFlag),
		.sleepFlag (q.sleepOn),
		.term      (terminalOut)
	);

	// decode helpers for the two selection settings
	function automatic logic cas_bus_dev(input logic [7:0] c);
		return c == psl_pkg::CAS_BUSDEV0 || c == psl_pkg::CAS_BUSDEV1;
	endfunction : cas_bus_dev

	function automatic logic cas_bus_sm(input logic [7:0] c);
		return c == psl_pkg::CAS_BUSSM0 || c == psl_pkg::CAS_BUSSM1;
	endfunction : cas_bus_sm

	function automatic logic cas_ana_dev(input logic [7:0] c);
		return c == psl_pkg::CAS_DEV_A0 || c == psl_pkg::CAS_DEV_A1
			|| c == psl_pkg::CAS_DEV_B0 || c == psl_pkg::CAS_DEV_B1;
	endfunction : cas_ana_dev

	function automatic logic las_limit_stop(input logic [7:0] a);
		return a == psl_pkg::LAS_1 || a == psl_pkg::LAS_3
			|| a == psl_pkg::LAS_11 || a == psl_pkg::LAS_13;
	endfunction : las_limit_stop

	function automatic logic las_dev_stop(input logic [7:0] a);
		return a == psl_pkg::LAS_2 || a == psl_pkg::LAS_3
			|| a == psl_pkg::LAS_12 || a == psl_pkg::LAS_13;
	endfunction : las_dev_stop

	logic                      setup;
	logic                      wrAccess;
	logic                      mapped;
	logic [31:0]               rdValue;
	logic [psl_pkg::EV_W-1:0]  liveEv;
	logic [psl_pkg::EV_W-1:0]  rise;
	logic [psl_pkg::EV_W-1:0]  clearMask;
	logic signed [DW-1:0]      setv;
	logic signed [DW-1:0]      meas;
	logic                      busMode;
	logic                      loopWanted;
	logic                      faultTrig;
	logic                      coast;
	logic                      decelSel;

	always_comb
	begin
		next_q = q;
		setup = psel && !penable;
		wrAccess = psel && penable && q.pready && pwrite && !q.pslverr;
		mapped = 1'b1;
		rdValue = 32'h0000_0000;
		// read mux; unmapped addresses answer zero with an error
		unique case (paddr)
			psl_pkg::ADDR_CTRL:   rdValue = {16'h0000, q.cas, q.las};
			psl_pkg::ADDR_UPPER:  rdValue = {16'h0000, q.upperLim};
			psl_pkg::ADDR_LOWER:  rdValue = {16'h0000, q.lowerLim};
			psl_pkg::ADDR_DEVLIM: rdValue = {16'h0000, q.devLim};
			psl_pkg::ADDR_SWITCH: rdValue = {16'h0000, q.switchFreq};
			psl_pkg::ADDR_INTTM:  rdValue = {16'h0000, q.detectTime};
			psl_pkg::ADDR_TERM_A: rdValue = q.code[3:0];
			psl_pkg::ADDR_TERM_B: rdValue = q.code[7:4];
			psl_pkg::ADDR_FLAGS:  rdValue = {22'h0, q.intClear, q.decel,
				q.shutoff, q.dirFlag, q.state == psl_pkg::LOOP_RUN, q.sleepOn,
				q.state == psl_pkg::LOOP_FAULT, devFlag, lowerFlag, upperFlag};
			psl_pkg::ADDR_STATUS: rdValue = {26'h0000000, q.status};
			psl_pkg::ADDR_MASK:   rdValue = {26'h0000000, q.mask};
			default:
			begin
				mapped = 1'b0;
				rdValue = 32'h0000_0000;
			end
		endcase
		// answer is prepared in setup, so the access phase has no wait
		next_q.pready = setup;
		next_q.pslverr = setup && !mapped;
		if (setup)
			next_q.prdata = pwrite ? 32'h0000_0000 : rdValue;
		if (setup)
			next_q.rdSnap = (!pwrite && paddr == psl_pkg::ADDR_STATUS) ? q.status : '0;
		// register writes at the access edge
		if (wrAccess)
		begin
			unique case (paddr)
				psl_pkg::ADDR_CTRL:
				begin
					next_q.las = pwdata[psl_pkg::CTRL_LAS_LSB +: 8];
					next_q.cas = pwdata[psl_pkg::CTRL_CAS_LSB +: 8];
				end
				psl_pkg::ADDR_UPPER:  next_q.upperLim = pwdata[15:0];
				psl_pkg::ADDR_LOWER:  next_q.lowerLim = pwdata[15:0];
				psl_pkg::ADDR_DEVLIM: next_q.devLim = pwdata[15:0];
				// out of range switchover values are dropped, old one stays
				psl_pkg::ADDR_SWITCH:
					if (pwdata[15:0] <= psl_pkg::SWITCH_MAX
						|| pwdata[15:0] == psl_pkg::DISABLE_VAL)
						next_q.switchFreq = pwdata[15:0];
				psl_pkg::ADDR_INTTM:  next_q.detectTime = pwdata[15:0];
				psl_pkg::ADDR_TERM_A: next_q.code[3:0] = pwdata;
				psl_pkg::ADDR_TERM_B: next_q.code[7:4] = pwdata;
				psl_pkg::ADDR_MASK:   next_q.mask = pwdata[psl_pkg::EV_W-1:0];
				default:              next_q.mask = q.mask;
			endcase
		end
		// value sources by control action selection
		busMode = cas_bus_dev(q.cas) || cas_bus_sm(q.cas);
		setv = cas_bus_sm(q.cas) ? DW'(busSetValue) : DW'(analogSetValue);
		meas = cas_bus_sm(q.cas) ? DW'(busMeasured) : DW'(analogMeasured);
		if (cas_bus_dev(q.cas))
			next_q.deviation = DW'(busDeviation);
		else if (cas_ana_dev(q.cas))
			next_q.deviation = DW'(analogDeviation);
		else
			next_q.deviation = setv - meas;
		next_q.measured = meas;
		// no measured value exists when a deviation is fed in directly
		next_q.gateLimits = !cas_ana_dev(q.cas) && !cas_bus_dev(q.cas);
		// loop supervision
		loopWanted = runActive && (loopEnableInput || busMode);
		faultTrig = ((upperFlag || lowerFlag) && las_limit_stop(q.las))
			|| (devFlag && las_dev_stop(q.las));
		unique case (q.state)
			psl_pkg::LOOP_OPEN:
				if (loopWanted && (q.switchFreq == psl_pkg::DISABLE_VAL
					|| outputFreq >= q.switchFreq))
					next_q.state = psl_pkg::LOOP_RUN;
			psl_pkg::LOOP_RUN:
				if (faultTrig)
					next_q.state = psl_pkg::LOOP_FAULT;
				else if (!loopWanted)
					next_q.state = psl_pkg::LOOP_OPEN;
			psl_pkg::LOOP_FAULT:
				next_q.state = psl_pkg::LOOP_FAULT;
			default:
				next_q.state = psl_pkg::LOOP_OPEN;
		endcase
		// loop-active kept as its own flop, so the pin carries no decode glitch
		next_q.loopOn = next_q.state == psl_pkg::LOOP_RUN;
		// output interruption and its stop manner
		next_q.sleepOn = sleepRequest && next_q.state == psl_pkg::LOOP_RUN
			&& q.detectTime != psl_pkg::DISABLE_VAL;
		coast = q.las <= psl_pkg::LAS_3;
		decelSel = q.las >= psl_pkg::LAS_10 && q.las <= psl_pkg::LAS_13;
		next_q.shutoff = next_q.state == psl_pkg::LOOP_FAULT
			|| (next_q.sleepOn && coast);
		next_q.decel = next_q.sleepOn && decelSel;
		next_q.dirFlag = runActive && dirForward;
		next_q.intClear = integralResetInput
			|| next_q.state != psl_pkg::LOOP_RUN;
		// sticky events; only bits handed out by the read are cleared
		liveEv = {next_q.state == psl_pkg::LOOP_RUN, next_q.sleepOn,
			next_q.state == psl_pkg::LOOP_FAULT, devFlag, lowerFlag, upperFlag};
		rise = liveEv & ~q.prevEv;
		next_q.prevEv = liveEv;
		clearMask = (psel && penable && q.pready && !pwrite
			&& paddr == psl_pkg::ADDR_STATUS) ? q.rdSnap : '0;
		next_q.status = (q.status & ~clearMask) | rise;
		next_q.irq = |(next_q.status & next_q.mask);
	end

	// one register stage for all state
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			q <= '0;
			q.las <= psl_pkg::RST_LAS;
			q.cas <= psl_pkg::RST_CAS;
			q.upperLim <= psl_pkg::RST_LIMIT;
			q.lowerLim <= psl_pkg::RST_LIMIT;
			q.devLim <= psl_pkg::RST_LIMIT;
			q.switchFreq <= psl_pkg::RST_SWITCH;
			q.detectTime <= psl_pkg::RST_INTTM;
			q.code <= {8{psl_pkg::RST_CODE}};
			q.mask <= psl_pkg::RST_MASK;
			q.state <= psl_pkg::LOOP_OPEN;
			q.intClear <= 1'b1;
		end
		else
			q <= next_q;
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign deviationOut = q.deviation;
	assign loopActive = q.loopOn;
	assign outputShutoff = q.shutoff;
	assign decelStop = q.decel;
	assign integralClear = q.intClear;
	assign irq = q.irq;
endmodule : psl_supervisor
`default_nettype wire

//--- sim/psl_supervisor_monitor.sv
`default_nettype none
module psl_supervisor_monitor (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic [7:0] paddr,
	input  wire logic       pready,
	input  wire logic       pslverr,
	input  wire logic       runActive,
	input  wire logic       loopEnableInput,
	input  wire logic       integralResetInput,
	input  wire logic       loopActive,
	input  wire logic       outputShutoff,
	input  wire logic       decelStop,
	input  wire logic       integralClear
);
	// one clock domain, so one default clocking and reset guard
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	// bus answers with zero wait states, one cycle only
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_access;
		pready |-> $past(psel && !penable);
	endproperty
	a_access: assert property (p_access) else $error("ready without setup");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready held too long");
	property p_err_map;
		pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h28);
	endproperty
	a_err_map: assert property (p_err_map) else $error("slave error wrong for address");

	// loop supervision levels
	property p_integral;
		integralResetInput |=> integralClear;
	endproperty
	a_integral: assert property (p_integral) else $error("integral not cleared");
	property p_loop_drop;
		!runActive |=> !loopActive;
	endproperty
	a_loop_drop: assert property (p_loop_drop) else $error("loop active while stopped");
	property p_latch;
		outputShutoff && !loopActive |=> outputShutoff;
	endproperty
	a_latch: assert property (p_latch) else $error("fault shutoff released");
	property p_excl;
		!(outputShutoff && decelStop);
	endproperty
	a_excl: assert property (p_excl) else $error("coast and decel together");
	// frequency must not throw the loop out once running
	property p_hold;
		loopActive && runActive && loopEnableInput |=> loopActive || outputShutoff;
	endproperty
	a_hold: assert property (p_hold) else $error("closed loop left while wanted");
endmodule : psl_supervisor_monitor

bind psl_supervisor psl_supervisor_monitor u_mon (
	.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .runActive(runActive),
	.loopEnableInput(loopEnableInput), .integralResetInput(integralResetInput),
	.loopActive(loopActive), .outputShutoff(outputShutoff), .decelStop(decelStop),
	.integralClear(integralClear)
);
`default_nettype wire

//--- sim/psl_tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                mclk = 1'b0;
	logic                reset = 1'b1;
	logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        [7:0]   paddr = 8'h00;
	logic        [31:0]  pwdata = 32'h0, prdata;
	logic                pready, pslverr, loopActive, outputShutoff, decelStop;
	logic                integralClear, irq;
	logic signed [15:0]  aSet = 16'h0, aMeas = 16'h0, aDev = 16'h0;
	logic signed [15:0]  bSet = 16'h0, bMeas = 16'h0, bDev = 16'h0;
	logic        [15:0]  freq = 16'h0;
	logic                run = 1'b0, fwd = 1'b0, loopEn = 1'b0, intRst = 1'b0, sleepReq = 1'b0;
	logic        [6:0]   term;
	logic signed [16:0]  devOut;
	int                  n_errors = 0, tests_run = 0, cycles = 0;

	psl_supervisor #(.VALUE_W(16), .NUM_TERM(7)) dut (
		.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.analogSetValue(aSet), .analogMeasured(aMeas), .analogDeviation(aDev),
		.busSetValue(bSet), .busMeasured(bMeas), .busDeviation(bDev), .outputFreq(freq),
		.runActive(run), .dirForward(fwd), .loopEnableInput(loopEn),
		.integralResetInput(intRst), .sleepRequest(sleepReq), .terminalOut(term),
		.deviationOut(devOut), .loopActive(loopActive), .outputShutoff(outputShutoff),
		.decelStop(decelStop), .integralClear(integralClear), .irq(irq));

	// 20 MHz clock
	always #25 mclk = ~mclk;

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("tests_run %0d n_errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chkb(input string what, input logic exp, input logic got);
		chk(what, {31'h0, exp}, {31'h0, got});
	endtask : chkb

	// settle n edges, then look at the falling edge where outputs are stable
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask : tick

	// one transfer; ready, data and error taken at the edge that sees ready high,
	// before the design updates at it; only the hang guard ends the wait
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge mclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wreg

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
		logic [31:0] d;
		logic        e;
		apb(1'b0, a, 32'h0, d, e);
		chk("read data", exp, d);
		chkb("slave error", expErr, e);
	endtask : rchk

	task automatic cfg(input logic [15:0] ctrl, up, lo, dv, sw, it, input logic [31:0] ta);
		wreg(psl_pkg::ADDR_CTRL, {16'h0, ctrl});
		wreg(psl_pkg::ADDR_UPPER, {16'h0, up});
		wreg(psl_pkg::ADDR_LOWER, {16'h0, lo});
		wreg(psl_pkg::ADDR_DEVLIM, {16'h0, dv});
		wreg(psl_pkg::ADDR_SWITCH, {16'h0, sw});
		wreg(psl_pkg::ADDR_INTTM, {16'h0, it});
		wreg(psl_pkg::ADDR_TERM_A, ta);
		wreg(psl_pkg::ADDR_MASK, 32'h3F);
	endtask : cfg

	// mid-run reset with the drive quiet
	task automatic rst();
		@(posedge mclk);
		reset <= 1'b1;
		run   <= 1'b0;
		loopEn <= 1'b0;
		sleepReq <= 1'b0;
		freq  <= 16'h0;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
	endtask : rst

	task automatic t_regs();
		rchk(psl_pkg::ADDR_CTRL, 32'h1400, 1'b0);
		rchk(psl_pkg::ADDR_UPPER, 32'h270F, 1'b0);
		rchk(8'h40, 32'h0, 1'b1);
		wreg(psl_pkg::ADDR_SWITCH, 32'h9C41);
		rchk(psl_pkg::ADDR_SWITCH, 32'h270F, 1'b0);
		wreg(psl_pkg::ADDR_SWITCH, 32'h9C40);
		rchk(psl_pkg::ADDR_SWITCH, 32'h9C40, 1'b0);
	endtask : t_regs

	// terminals: upper, upper inverted, direction, loop active
	task automatic t_upper();
		rst();
		cfg(16'h1401, 16'h64, 16'h270F, 16'h270F, 16'h270F, 16'h270F, 32'h2F10730F);
		@(posedge mclk);
		run   <= 1'b1;
		loopEn <= 1'b1;
		fwd   <= 1'b1;
		aMeas <= 16'h64;
		tick(6);
		chk("terminals", 32'hE, {28'h0, term[3:0]});
		rchk(psl_pkg::ADDR_FLAGS, 32'h60, 1'b0);
		@(posedge mclk);
		aMeas <= 16'h65;
		tick(6);
		chk("terminals", 32'h5, {28'h0, term[3:0]});
		chkb("shutoff", 1'b1, outputShutoff);
		chkb("irq", 1'b1, irq);
		rchk(psl_pkg::ADDR_STATUS, 32'h29, 1'b0);
		tick(2);
		chkb("irq", 1'b0, irq);
		@(posedge mclk);
		aMeas <= 16'h32;
		run   <= 1'b0;
		tick(6);
		chkb("shutoff", 1'b1, outputShutoff);
		chk("terminals", 32'h2, {28'h0, term[3:0]});
	endtask : t_upper

	// terminals: lower, lower inverted, deviation, deviation inverted
	task automatic t_lowdev();
		rst();
		cfg(16'h1402, 16'h270F, 16'h64, 16'h270F, 16'h270F, 16'h270F, 32'h9430720E);
		@(posedge mclk);
		run   <= 1'b1;
		loopEn <= 1'b1;
		aSet  <= 16'h0;
		aMeas <= 16'h50;
		tick(6);
		chk("terminals", 32'h9, {28'h0, term[3:0]});
		chkb("shutoff", 1'b0, outputShutoff);
		wreg(psl_pkg::ADDR_DEVLIM, 32'h4F);
		tick(6);
		chk("terminals", 32'h5, {28'h0, term[3:0]});
		chkb("shutoff", 1'b1, outputShutoff);
	endtask : t_lowdev

	task automatic t_switch();
		rst();
		cfg(16'h1400, 16'h270F, 16'h270F, 16'h270F, 16'h3E8, 16'h270F, 32'h0);
		@(posedge mclk);
		run   <= 1'b1;
		loopEn <= 1'b1;
		freq  <= 16'h3E7;
		tick(4);
		chkb("loop", 1'b0, loopActive);
		chkb("int clear", 1'b1, integralClear);
		@(posedge mclk);
		freq <= 16'h3E8;
		tick(4);
		chkb("loop", 1'b1, loopActive);
		chkb("int clear", 1'b0, integralClear);
		@(posedge mclk);
		intRst <= 1'b1;
		freq   <= 16'h0;
		tick(4);
		chkb("int clear", 1'b1, integralClear);
		chkb("loop", 1'b1, loopActive);
		@(posedge mclk);
		intRst <= 1'b0;
		run    <= 1'b0;
		tick(4);
		chkb("loop", 1'b0, loopActive);
	endtask : t_switch

	task automatic t_sleep();
		logic [7:0] las [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
		rst();
		cfg(16'h140A, 16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h270F, 32'hAA46);
		@(posedge mclk);
		run      <= 1'b1;
		loopEn   <= 1'b1;
		sleepReq <= 1'b1;
		tick(4);
		chk("terminals", 32'h2, {30'h0, term[1:0]});
		chkb("decel", 1'b0, decelStop);
		wreg(psl_pkg::ADDR_INTTM, 32'hA);
		wreg(psl_pkg::ADDR_TERM_B, 32'h0046AA46);
		tick(4);
		chk("terminals", 32'h51, {25'h0, term});
		chkb("loop", 1'b1, loopActive);
		// every limit action setting, coast below ten and decel from ten
		foreach (las[i])
		begin
			wreg(psl_pkg::ADDR_CTRL, {16'h0, 8'h14, las[i]});
			tick(4);
			chkb("decel", las[i] >= 8'h0A, decelStop);
			chkb("coast", las[i] < 8'h0A, outputShutoff);
		end
	endtask : t_sleep

	task automatic t_bus();
		rst();
		cfg(16'h3200, 16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h270F, 32'h0);
		@(posedge mclk);
		run   <= 1'b1;
		bDev  <= 16'h7B;
		aDev  <= 16'h5;
		bSet  <= 16'h1F4;
		bMeas <= 16'h64;
		aSet  <= 16'h9;
		aMeas <= 16'h2;
		tick(4);
		chkb("loop", 1'b1, loopActive);
		chk("deviation", 32'h7B, 32'(devOut));
		wreg(psl_pkg::ADDR_CTRL, 32'h3C00);
		tick(4);
		chk("deviation", 32'h190, 32'(devOut));
		wreg(psl_pkg::ADDR_CTRL, 32'h1400);
		tick(4);
		chkb("loop", 1'b0, loopActive);
		chk("deviation", 32'h7, 32'(devOut));
		wreg(psl_pkg::ADDR_CTRL, 32'h0A00);
		tick(4);
		chk("deviation", 32'h5, 32'(devOut));
	endtask : t_bus

	// main sequence
	initial
	begin
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		t_regs();
		t_upper();
		t_lowdev();
		t_switch();
		t_sleep();
		t_bus();
		print_verdict();
	end
endmodule : tb
`default_nettype wire
